// >>> verilog/mres_regs.svh
// Register map, field widths and timing constants for the receive error
// statistics block; assumes an AXI4-Lite slave with 32-bit data.
`ifndef MRES_REGS_SVH
`define MRES_REGS_SVH
`define MRES_OFS_OVERRUN 8'h00
`define MRES_OFS_SYMERR 8'h04
`define MRES_OFS_OVERSIZE 8'h08
`define MRES_OFS_JABBER 8'h0c
`define MRES_OFS_UNDERSIZE 8'h10
`define MRES_OFS_HEARTBEAT 8'h14
`define MRES_OFS_LENMIS 8'h18
`define MRES_OFS_FCSALIGN 8'h1c
`define MRES_OFS_CONFIG 8'h20
`define MRES_OFS_IRQ_STAT 8'h24
`define MRES_OFS_IRQ_MASK 8'h28
`define MRES_CFG_LONG_BIT 8
`define MRES_CFG_LCHK_BIT 16
`define MRES_CFG_FDX_BIT 0
`define MRES_MIN_LEN 14'h0040
`define MRES_MAX_LEN 14'h05ee
`define MRES_MAX_LEN_LONG 14'h0600
`define MRES_TYPE_THRESH 16'h0600
`define MRES_SQE_BITS 96
`define MRES_BIT_NS 10
`define MRES_CLK_NS 10
`define MRES_RESP_OKAY 2'b00
`define MRES_RESP_SLVERR 2'b10
`endif

// >>> verilog/mres_pkg.sv
// Types shared by the receive error statistics block.
// Assumes the register header is included by the modules.
package mres_pkg;
   // Counter indices in the counter bank
   typedef enum logic [2:0] {
      MRES_CNT_OVERRUN = 3'b000,
      MRES_CNT_SYMERR = 3'b001,
      MRES_CNT_OVERSIZE = 3'b010,
      MRES_CNT_JABBER = 3'b011,
      MRES_CNT_UNDERSIZE = 3'b100,
      MRES_CNT_HEARTBEAT = 3'b101,
      MRES_CNT_LENMIS = 3'b110,
      MRES_CNT_FCSALIGN = 3'b111
   } mres_cnt_t;
   // Heartbeat watch states
   typedef enum logic [1:0] {
      MRES_HB_IDLE = 2'b00,
      MRES_HB_WAIT = 2'b01
   } mres_hb_t;
endpackage : mres_pkg

// >>> verilog/mres_counter.sv
// One saturating-free statistics counter with a software load port.
// Assumes the caller pulses inc for one cycle per event.
`timescale 1ns/10ps
module mres_counter #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys, // System clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic inc, // Count one event
   input wire logic load, // Software write strobe
   input wire logic [WIDTH-1:0] load_val, // Value written by software
   output logic [WIDTH-1:0] count // Present count
);
   logic [WIDTH-1:0] count_q;
   // A write replaces the value; an event in the same cycle is added on top,
   // so no event is lost to a software write
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         count_q <= '0;
      end else if (load) begin
         count_q <= load_val + WIDTH'(inc);
      end else if (inc) begin
         count_q <= count_q + 1'b1; // Wraps like the other counters
      end
   end
   assign count = count_q;
endmodule : mres_counter

// >>> verilog/mres_heartbeat.sv
// Heartbeat (SQE test) watch after each transmitted frame in half duplex.
// Assumes tx_en and the collision indication are synchronous to clk_sys.
`timescale 1ns/10ps
`include "mres_regs.svh"
module mres_heartbeat
   import mres_pkg::*;
#(
   parameter int WIN_CYC = (`MRES_SQE_BITS * `MRES_BIT_NS) / `MRES_CLK_NS
) (
   input wire logic clk_sys, // System clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic half_duplex, // Link runs half duplex
   input wire logic tx_en, // Transmit enable from the transmit engine
   input wire logic collision_indication, // Collision from the PHY
   output logic hb_fail // One-cycle pulse on a missed heartbeat
);
   mres_hb_t state_q;
   logic tx_en_q;
   logic [$clog2(WIN_CYC+1)-1:0] cnt_q;
   logic fail_q;
   // Window opens on the falling edge of tx_en; a longest time rounds down
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_q <= MRES_HB_IDLE;
         tx_en_q <= 1'b0;
         cnt_q <= '0;
         fail_q <= 1'b0;
      end else begin
         tx_en_q <= tx_en;
         fail_q <= 1'b0;
         unique case (state_q)
            MRES_HB_IDLE: begin
               if (tx_en_q && !tx_en && half_duplex) begin
                  state_q <= MRES_HB_WAIT;
                  cnt_q <= '0;
               end
            end
            MRES_HB_WAIT: begin
               if (collision_indication) begin
                  state_q <= MRES_HB_IDLE;
               end else if (cnt_q == ($bits(cnt_q))'(WIN_CYC - 1)) begin
                  state_q <= MRES_HB_IDLE;
                  fail_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         endcase
      end
   end
   assign hb_fail = fail_q;
   // Failure follows a cycle spent in the wait state
   property p_hb_quiet;
      @(posedge clk_sys) disable iff (!resetn)
      $rose(hb_fail) |-> $past(state_q) == MRES_HB_WAIT;
   endproperty
   a_hb_quiet: assert property (p_hb_quiet) else $error("hb no wait");
endmodule : mres_heartbeat

// >>> verilog/mres_top.sv
// Receive error statistics counters with an AXI4-Lite register slave.
// Assumes one-cycle frame-status strobes from the receive engine and
// transmit signals from the transmit engine, all on clk_sys.
`timescale 1ns/10ps
`include "mres_regs.svh"
module mres_top
   import mres_pkg::*;
#(
   parameter int CNT_W = 8,
   parameter int NCNT = 8,
   parameter int HB_WIN_CYC = (`MRES_SQE_BITS * `MRES_BIT_NS) / `MRES_CLK_NS
) (
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic resetn, // Synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic rx_frame_done, // Pulse: a received frame has ended
   input wire logic [13:0] rx_frame_len, // Measured frame length in bytes
   input wire logic [15:0] rx_len_type, // Bytes 13 and 14 of the frame
   input wire logic rx_addr_match, // Frame address was recognised
   input wire logic rx_dma_overrun, // Frame lost to receive DMA overrun
   input wire logic rx_symbol_err, // rx_er was seen during the frame
   input wire logic rx_crc_err, // Frame check sequence was bad
   input wire logic rx_align_err, // Frame not a whole number of bytes
   input wire logic tx_en, // Transmit enable
   input wire logic collision_indication, // Collision from the PHY
   output logic irq // Level interrupt
);
   logic [31:0] cfg_q;
   logic [NCNT-1:0] irq_stat_q;
   logic [NCNT-1:0] irq_mask_q;
   logic [NCNT-1:0] ev;
   logic [NCNT-1:0] ld;
   logic [CNT_W-1:0] cnt [NCNT];
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_go;
   logic hb_fail;
   logic [13:0] max_len;
   logic too_long;
   logic too_short;
   logic bad_crc;
   logic any_err;
   logic [7:0] araddr_w;

   // Long-frame bit lifts the length ceiling for every classification
   assign max_len = cfg_q[`MRES_CFG_LONG_BIT] ? `MRES_MAX_LEN_LONG
                                              : `MRES_MAX_LEN;
   assign too_long = rx_frame_len > max_len;
   assign too_short = rx_frame_len < `MRES_MIN_LEN;
   assign bad_crc = rx_crc_err | rx_align_err;
   assign any_err = bad_crc | rx_symbol_err;

   // Frame classification; each event is a one-cycle pulse
   always_comb begin
      ev = '0;
      ev[MRES_CNT_OVERRUN] = rx_frame_done & rx_addr_match
                             & rx_dma_overrun;
      ev[MRES_CNT_SYMERR] = rx_frame_done & rx_symbol_err;
      ev[MRES_CNT_FCSALIGN] = rx_frame_done & rx_symbol_err
                              & !too_long & !too_short;
      ev[MRES_CNT_OVERSIZE] = rx_frame_done & too_long & !any_err;
      ev[MRES_CNT_JABBER] = rx_frame_done & too_long & any_err;
      ev[MRES_CNT_UNDERSIZE] = rx_frame_done & too_short & !any_err;
      ev[MRES_CNT_HEARTBEAT] = hb_fail;
      ev[MRES_CNT_LENMIS] = rx_frame_done
                            & cfg_q[`MRES_CFG_LCHK_BIT]
                            & (rx_len_type < `MRES_TYPE_THRESH)
                            & !too_long
                            & ({2'b00, rx_frame_len} < rx_len_type);
   end

   // Heartbeat watch runs only in half duplex
   mres_heartbeat #(
      .WIN_CYC(HB_WIN_CYC)
   ) u_hb (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .half_duplex(!cfg_q[`MRES_CFG_FDX_BIT]),
      .tx_en(tx_en),
      .collision_indication(collision_indication),
      .hb_fail(hb_fail)
   );

   // Counter bank, one counter per statistic
   genvar gi;
   generate
      for (gi = 0; gi < NCNT; gi++) begin : g_cnt
         assign ld[gi] = wr_go && wstrb_q[0]
                         && (awaddr_q == 8'(gi * 4));
         mres_counter #(
            .WIDTH(CNT_W)
         ) u_cnt (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .inc(ev[gi]),
            .load(ld[gi]),
            .load_val(wdata_q[CNT_W-1:0]),
            .count(cnt[gi])
         );
      end
   endgenerate

   // Write side: address and data are latched in either order
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign wr_go = aw_have_q && w_have_q && !bvalid_q;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `MRES_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= (awaddr_q > `MRES_OFS_IRQ_MASK) ? `MRES_RESP_SLVERR
                                                   : `MRES_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Configuration register; only the defined bits are kept
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cfg_q <= 32'h0000_0000;
      end else if (wr_go && awaddr_q == `MRES_OFS_CONFIG) begin
         cfg_q <= wdata_q & ((32'h1 << `MRES_CFG_LONG_BIT)
                           | (32'h1 << `MRES_CFG_LCHK_BIT)
                           | (32'h1 << `MRES_CFG_FDX_BIT));
      end
   end

   // Sticky event bits; a new event wins over a write-one clear
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_stat_q <= '0;
      end else if (wr_go && awaddr_q == `MRES_OFS_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~wdata_q[NCNT-1:0]) | ev;
      end else begin
         irq_stat_q <= irq_stat_q | ev;
      end
   end

   // Interrupt mask, same layout as the status bits
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_mask_q <= '0;
      end else if (wr_go && awaddr_q == `MRES_OFS_IRQ_MASK) begin
         irq_mask_q <= wdata_q[NCNT-1:0];
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // Read side: one read under way, data registered
   assign s_axi_arready = !rvalid_q;
   assign araddr_w = {s_axi_araddr[7:2], 2'b00}; // Word address
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `MRES_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= `MRES_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         if (s_axi_araddr[7:2] < 6'(NCNT)) begin
            rdata_q <= 32'(cnt[s_axi_araddr[4:2]]);
         end else if (araddr_w == `MRES_OFS_CONFIG) begin
            rdata_q <= cfg_q;
         end else if (araddr_w == `MRES_OFS_IRQ_STAT) begin
            rdata_q <= 32'(irq_stat_q);
         end else if (araddr_w == `MRES_OFS_IRQ_MASK) begin
            rdata_q <= 32'(irq_mask_q);
         end else begin
            rresp_q <= `MRES_RESP_SLVERR; // Unmapped address
         end
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Named steps of a classified frame
   sequence s_frame_long;
      rx_frame_done && too_long;
   endsequence

   property p_overrun;
      @(posedge clk_sys) disable iff (!resetn)
      (rx_frame_done && rx_addr_match && rx_dma_overrun && !ld[0])
         |=> cnt[MRES_CNT_OVERRUN] == $past(cnt[MRES_CNT_OVERRUN]) + 1'b1;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun miss");

   property p_symerr;
      @(posedge clk_sys) disable iff (!resetn)
      (rx_frame_done && rx_symbol_err && !ld[1])
         |=> cnt[MRES_CNT_SYMERR] == $past(cnt[MRES_CNT_SYMERR]) + 1'b1;
   endproperty
   a_symerr: assert property (p_symerr) else $error("symbol miss");

   property p_fcs;
      @(posedge clk_sys) disable iff (!resetn)
      (rx_frame_done && rx_symbol_err && rx_frame_len == `MRES_MIN_LEN)
         |-> ev[MRES_CNT_FCSALIGN];
   endproperty
   a_fcs: assert property (p_fcs) else $error("fcs miss");

   property p_jab_not_fcs;
      @(posedge clk_sys) disable iff (!resetn)
      s_frame_long |-> !ev[MRES_CNT_FCSALIGN] && (ev[MRES_CNT_JABBER]
         == any_err);
   endproperty
   a_jab_not_fcs: assert property (p_jab_not_fcs) else $error("jab");

   property p_long_cfg;
      @(posedge clk_sys) disable iff (!resetn)
      (rx_frame_done && rx_frame_len == `MRES_MAX_LEN_LONG && !any_err)
         |-> ev[MRES_CNT_OVERSIZE] != cfg_q[`MRES_CFG_LONG_BIT];
   endproperty
   a_long_cfg: assert property (p_long_cfg) else $error("long cfg");

   property p_oversize;
      @(posedge clk_sys) disable iff (!resetn)
      s_frame_long ##0 !any_err |-> ev[MRES_CNT_OVERSIZE];
   endproperty
   a_oversize: assert property (p_oversize) else $error("oversize");

   property p_under;
      @(posedge clk_sys) disable iff (!resetn)
      ev[MRES_CNT_UNDERSIZE] |-> rx_frame_len < `MRES_MIN_LEN && !any_err;
   endproperty
   a_under: assert property (p_under) else $error("undersize");

   property p_lenmis;
      @(posedge clk_sys) disable iff (!resetn)
      ev[MRES_CNT_LENMIS] |-> cfg_q[`MRES_CFG_LCHK_BIT] && !too_long
         && rx_len_type < `MRES_TYPE_THRESH; 
   endproperty
   a_lenmis: assert property (p_lenmis) else $error("len mismatch");

   // Counter-level checks: jabber, mismatch and heartbeat events must really reach their registers
   sequence s_len_short;
      rx_frame_done && cfg_q[`MRES_CFG_LCHK_BIT]
         && ({2'b00, rx_frame_len} < rx_len_type);
   endsequence

   property p_jabber;
      @(posedge clk_sys) disable iff (!resetn)
      s_frame_long ##0 (any_err && !ld[MRES_CNT_JABBER])
         |=> cnt[MRES_CNT_JABBER] == $past(cnt[MRES_CNT_JABBER]) + 1'b1;
   endproperty
   a_jabber: assert property (p_jabber) else $error("jabber miss");

   property p_lencnt;
      @(posedge clk_sys) disable iff (!resetn)
      s_len_short ##0 (!too_long && rx_len_type < `MRES_TYPE_THRESH
         && !ld[MRES_CNT_LENMIS])
         |=> cnt[MRES_CNT_LENMIS] == $past(cnt[MRES_CNT_LENMIS]) + 1'b1;
   endproperty
   a_lencnt: assert property (p_lencnt) else $error("len count");

   property p_type_id;
      @(posedge clk_sys) disable iff (!resetn)
      rx_frame_done && rx_len_type >= `MRES_TYPE_THRESH
         |-> !ev[MRES_CNT_LENMIS];
   endproperty
   a_type_id: assert property (p_type_id) else $error("type id");

   // A too-long frame leaves the mismatch count alone unless software wrote it
   property p_nomis;
      @(posedge clk_sys) disable iff (!resetn)
      s_frame_long |=> cnt[MRES_CNT_LENMIS] == $past(cnt[MRES_CNT_LENMIS])
         || $past(ld[MRES_CNT_LENMIS]);
   endproperty
   a_nomis: assert property (p_nomis) else $error("long mis");

   property p_lchk_off;
      @(posedge clk_sys) disable iff (!resetn)
      !cfg_q[`MRES_CFG_LCHK_BIT] && !ld[MRES_CNT_LENMIS]
         |=> $stable(cnt[MRES_CNT_LENMIS]);
   endproperty
   a_lchk_off: assert property (p_lchk_off) else $error("lchk off");

   property p_rd_upper;
      @(posedge clk_sys) disable iff (!resetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] < 6'(NCNT)
         |=> s_axi_rdata[31:CNT_W] == '0;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper bits");

   property p_load;
      @(posedge clk_sys) disable iff (!resetn)
      ld[MRES_CNT_OVERRUN] && !ev[MRES_CNT_OVERRUN]
         |=> cnt[MRES_CNT_OVERRUN] == $past(wdata_q[CNT_W-1:0]);
   endproperty
   a_load: assert property (p_load) else $error("load miss");

   property p_hb_cnt;
      @(posedge clk_sys) disable iff (!resetn)
      hb_fail && !ld[MRES_CNT_HEARTBEAT]
         |=> cnt[MRES_CNT_HEARTBEAT] == $past(cnt[MRES_CNT_HEARTBEAT]) + 1'b1;
   endproperty
   a_hb_cnt: assert property (p_hb_cnt) else $error("hb count");
endmodule : mres_top

// >>> verification/mres_phy_model.sv
// Far-side model of the PHY for the heartbeat (SQE test) path.
// Assumes tx_en is driven by the bench on clk_sys, as the MAC would drive it.
`timescale 1ns/10ps
module mres_phy_model (
   input wire logic clk_sys, // System clock
   input wire logic tx_en, // Transmit enable seen on the wire
   input wire logic answer, // Whether a heartbeat pulse is sent at all
   input wire logic [7:0] delay, // Cycles from end of transmit to pulse
   output logic collision_indication // Collision/heartbeat towards the MAC
);
   logic tx_en_q = 1'b0;
   int cnt_q = 1000;
   initial collision_indication = 1'b0;
   // Count from the fall of tx_en; 1000 means no frame pending
   always @(posedge clk_sys) begin
      tx_en_q <= tx_en;
      if (tx_en_q && !tx_en) begin
         cnt_q <= 0;
      end else if (cnt_q < 1000) begin
         cnt_q <= cnt_q + 1;
      end
      // Two-cycle pulse, so a late sampler cannot miss it
      collision_indication <= answer && cnt_q >= int'(delay)
         && cnt_q < int'(delay) + 2;
   end
endmodule : mres_phy_model

// >>> verification/testbench.sv
// Self-checking bench for the receive error statistics block.
// Assumes the register map header and an AXI4-Lite slave as in the design.
`timescale 1ns/10ps
`include "mres_regs.svh"
module testbench;
   import mres_pkg::*;
   localparam int HBW = 8; // Short heartbeat window keeps the run brief
   localparam int LIMIT = 30000;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq, collision_indication;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic rx_frame_done = 1'b0, rx_addr_match = 1'b0, rx_dma_overrun = 1'b0;
   logic rx_symbol_err = 1'b0, rx_crc_err = 1'b0, rx_align_err = 1'b0;
   logic [13:0] rx_frame_len = 14'h0;
   logic [15:0] rx_len_type = 16'h0;
   logic tx_en = 1'b0, hb_answer = 1'b0;
   logic [7:0] hb_delay = 8'h00;
   logic [7:0] e[8] = '{default: 8'h00}; // Expected counter values
   logic [31:0] rdv;
   int err_total = 0, tests_run = 0, cycles = 0;

   mres_top #(.HB_WIN_CYC(HBW)) i_mres_top (.clk_sys, .resetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .rx_frame_done, .rx_frame_len, .rx_len_type,
      .rx_addr_match, .rx_dma_overrun, .rx_symbol_err, .rx_crc_err,
      .rx_align_err, .tx_en, .collision_indication, .irq);
   mres_phy_model i_mres_phy_model (.clk_sys, .tx_en, .answer(hb_answer),
      .delay(hb_delay), .collision_indication);

   always #5 clk_sys = ~clk_sys;
   // Hang guard: counts as a mismatch and closes the run
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Write: both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic ta, tw, ka, kw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw)) begin
         // Sample mid-cycle: inputs only move just after a rising edge
         @(negedge clk_sys);
         ka = s_axi_awvalid && s_axi_awready;
         kw = s_axi_wvalid && s_axi_wready;
         @(posedge clk_sys);
         if (ka) s_axi_awvalid <= 1'b0;
         if (kw) s_axi_wvalid <= 1'b0;
         ta = ta | ka;
         tw = tw | kw;
      end
      do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask : rd

   // One frame end; f = {addr match, overrun, symbol, crc, align}
   task automatic frame(input logic [13:0] l, input logic [15:0] t,
                        input logic [4:0] f);
      @(posedge clk_sys);
      rx_frame_done <= 1'b1;
      rx_frame_len <= l;
      rx_len_type <= t;
      {rx_addr_match, rx_dma_overrun, rx_symbol_err, rx_crc_err,
       rx_align_err} <= f;
      @(posedge clk_sys);
      rx_frame_done <= 1'b0;
   endtask : frame

   // Every counter against its expectation; upper bits must read zero
   task automatic check_all;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 8; i++) begin
         rd(8'(4 * i), d, r);
         chk(d, {24'h0, e[i]});
      end
   endtask : check_all

   task automatic t_regs;
      check_all();
      rd(`MRES_OFS_CONFIG, rdv, resp);
      chk(rdv, 32'h0);
      rd(8'h2c, rdv, resp);
      chk({30'h0, resp}, {30'h0, `MRES_RESP_SLVERR});
      wr(8'h30, 32'h1, resp);
      chk({30'h0, resp}, {30'h0, `MRES_RESP_SLVERR});
      wr(`MRES_OFS_OVERRUN, 32'hffffff7e, resp);
      chk({30'h0, resp}, {30'h0, `MRES_RESP_OKAY});
      e[0] = 8'h7e;
      check_all();
      wr(`MRES_OFS_OVERRUN, 32'h000000ff, resp);
      frame(14'd100, 16'h0800, 5'b11000);
      e[0] = 8'h00;
      check_all();
      $display("test registers done");
   endtask : t_regs

   task automatic t_sizes;
      frame(14'd100, 16'h0800, 5'b11000);
      e[0]++;
      frame(14'd64, 16'h0800, 5'b10100);
      frame(14'd1518, 16'h0800, 5'b10100);
      e[1] += 2;
      e[7] += 2;
      frame(14'd1519, 16'h0800, 5'b10100);
      e[1]++;
      frame(14'd1519, 16'h0800, 5'b10010);
      frame(14'd1519, 16'h0800, 5'b10001);
      e[3] += 3;
      frame(14'd1519, 16'h0800, 5'b10000);
      e[2]++;
      frame(14'd1518, 16'h0800, 5'b10000);
      frame(14'd64, 16'h0800, 5'b10000);
      frame(14'd63, 16'h0800, 5'b10000);
      e[4]++;
      frame(14'd63, 16'h0800, 5'b10010);
      check_all();
      wr(`MRES_OFS_CONFIG, 32'h00000100, resp);
      frame(14'd1536, 16'h0800, 5'b10000);
      frame(14'd1537, 16'h0800, 5'b10000);
      e[2]++;
      frame(14'd1536, 16'h0800, 5'b10100);
      e[7]++;
      frame(14'd1537, 16'h0800, 5'b10100);
      e[1] += 2;
      e[3]++;
      check_all();
      wr(`MRES_OFS_CONFIG, 32'h0, resp);
      $display("test frame sizes done");
   endtask : t_sizes

   task automatic t_length;
      wr(`MRES_OFS_CONFIG, 32'h00010000, resp);
      frame(14'd100, 16'd200, 5'b10000);
      frame(14'd100, 16'h05ff, 5'b10000);
      e[6] += 2;
      frame(14'd100, 16'h0600, 5'b10000);
      frame(14'd100, 16'd100, 5'b10000);
      frame(14'd1520, 16'h05ff, 5'b10000);
      e[2]++;
      check_all();
      wr(`MRES_OFS_CONFIG, 32'h0, resp);
      frame(14'd100, 16'd200, 5'b10000);
      check_all();
      $display("test length field done");
   endtask : t_length

   // Send one frame; the window is HBW cycles, so wait well past it
   task automatic send(input logic ans, input logic [7:0] dly);
      @(posedge clk_sys);
      hb_answer <= ans;
      hb_delay <= dly;
      tx_en <= 1'b1;
      repeat (5) @(posedge clk_sys);
      tx_en <= 1'b0;
      repeat (HBW + 12) @(posedge clk_sys);
   endtask : send

   task automatic t_heartbeat;
      send(1'b1, 8'd0);
      send(1'b1, 8'd3);
      send(1'b0, 8'd0);
      e[5]++;
      check_all();
      wr(`MRES_OFS_CONFIG, 32'h00000001, resp);
      send(1'b0, 8'd0);
      check_all();
      wr(`MRES_OFS_CONFIG, 32'h0, resp);
      $display("test heartbeat done");
   endtask : t_heartbeat

   task automatic t_irq;
      wr(`MRES_OFS_IRQ_STAT, 32'hffffffff, resp);
      rd(`MRES_OFS_IRQ_STAT, rdv, resp);
      chk(rdv, 32'h0);
      wr(`MRES_OFS_IRQ_MASK, 32'h00000001, resp);
      frame(14'd100, 16'h0800, 5'b10100);
      @(negedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      frame(14'd100, 16'h0800, 5'b11000);
      @(negedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      rd(`MRES_OFS_IRQ_STAT, rdv, resp);
      chk(rdv, 32'h00000083);
      wr(`MRES_OFS_IRQ_STAT, 32'h00000001, resp);
      @(negedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      rd(`MRES_OFS_IRQ_STAT, rdv, resp);
      chk(rdv, 32'h00000082);
      e[0]++;
      e[1]++;
      e[7]++;
      check_all();
      $display("test interrupt done");
   endtask : t_irq

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs();
      t_sizes();
      t_length();
      t_heartbeat();
      t_irq();
      conclude();
   end
endmodule : testbench
